// File: omsi_pkg.sv
// Shared constants and helpers for the overlap mode select/interrupt port
`default_nettype none
package omsi_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned DD_W = 16;
  localparam logic [2:0] DA_DATA = 3'h0;
  localparam logic [2:0] DA_ERR = 3'h1;
  localparam logic [2:0] DA_SECCNT = 3'h2;
  localparam logic [2:0] DA_SECNUM = 3'h3;
  localparam logic [2:0] DA_CYLLO = 3'h4;
  localparam logic [2:0] DA_CYLHI = 3'h5;
  localparam logic [2:0] DA_DEVHEAD = 3'h6;
  localparam logic [2:0] DA_STATCMD = 3'h7;
  localparam logic [2:0] DA_ALTCTL = 3'h6;
  localparam int unsigned DEV_BIT = 4;
  localparam int unsigned INTERRUPT_DISABLE_BIT_BIT = 1;
  localparam int unsigned BSY_BIT = 7;
  localparam int unsigned OVL_BIT = 15;
  localparam int unsigned TAG_LSB = 8;
  localparam int unsigned TAG_W = 4;
  // Host controller register map (byte addresses, one word each)
  localparam logic [3:0] REG_OP = 4'h0;
  localparam logic [3:0] REG_WDATA = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam int unsigned OP_WR_BIT = 0;
  localparam int unsigned OP_DA_LSB = 1;
  localparam int unsigned OP_CS0_BIT = 4;
  localparam int unsigned OP_CS1_BIT = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Host strobe timing, ns
  localparam int unsigned SETUP_NS = 70;
  localparam int unsigned STROBE_NS = 165;
  localparam int unsigned RECOVER_NS = 70;

  function automatic int unsigned ns2cyc(input int unsigned ns);
    return (ns * CLK_MHZ + 999) / 1000;
  endfunction : ns2cyc

  localparam logic [7:0] SETUP_CYC = 8'(ns2cyc(SETUP_NS));
  localparam logic [7:0] STROBE_CYC = 8'(ns2cyc(STROBE_NS));
  localparam logic [7:0] RECOVER_CYC = 8'(ns2cyc(RECOVER_NS));

  // Returns {command block hit, control block hit} for this device
  function automatic logic [1:0] omsi_decode(input logic cs0_n,
      input logic cs1_n, input logic [2:0] da, input logic dev1,
      input logic csmode);
    logic cmd;
    logic ctl;
    cmd = 1'b0;
    ctl = 1'b0;
    if (csmode) begin
      cmd = !cs0_n && (cs1_n != dev1);
      ctl = cs0_n && (cs1_n != dev1) && (da == DA_ALTCTL);
    end else begin
      cmd = !cs0_n && cs1_n;
      ctl = cs0_n && !cs1_n && (da == DA_ALTCTL);
    end
    return {cmd, ctl};
  endfunction : omsi_decode
endpackage : omsi_pkg
`default_nettype wire

// File: omsi_bus_if.sv
// Shared cable between host adapter and two overlap-capable devices
`default_nettype none
interface omsi_bus_if;
  logic host_cs0_n;
  logic host_cs1_n;
  logic [2:0] host_da;
  logic host_dior_n;
  logic host_diow_n;
  logic [15:0] host_dd_o;
  logic host_dd_oe_n;
  logic [15:0] dev_dd_o;
  logic dev_dd_oe_n;
  logic dev_intrq_o;
  logic dev_intrq_oe_n;
  logic dev_second_interrupt_request_oe_n;
  // Other device on the cable, driven by the bench
  logic [15:0] ext_dd_o;
  logic ext_dd_oe_n;
  logic ext_intrq_o;
  logic ext_intrq_oe_n;
  logic ext_second_interrupt_request_oe_n;
  // Resolved wire levels; data pulled up, interrupt pulled down
  logic [15:0] dd;
  logic intrq;
  logic second_interrupt_request_n;
  assign dd = !host_dd_oe_n ? host_dd_o :
              !dev_dd_oe_n ? dev_dd_o :
              !ext_dd_oe_n ? ext_dd_o : 16'hFFFF;
  assign intrq = (!dev_intrq_oe_n && dev_intrq_o) ||
                 (!ext_intrq_oe_n && ext_intrq_o);
  // Open collector: any enabled driver pulls low
  assign second_interrupt_request_n = dev_second_interrupt_request_oe_n && ext_second_interrupt_request_oe_n;

  modport host (
    output host_cs0_n, host_cs1_n, host_da, host_dior_n, host_diow_n,
    output host_dd_o, host_dd_oe_n,
    input dd, intrq, second_interrupt_request_n
  );
  modport device (
    input host_cs0_n, host_cs1_n, host_da, host_dior_n, host_diow_n,
    input dd,
    output dev_dd_o, dev_dd_oe_n, dev_intrq_o, dev_intrq_oe_n,
    output dev_second_interrupt_request_oe_n
  );
endinterface : omsi_bus_if
`default_nettype wire

// File: omsi_sync.sv
// Two-flop synchroniser for cable inputs
`default_nettype none
module omsi_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } omsi_sync_s;
  omsi_sync_s r;
  omsi_sync_s n;

  if (W < 1) begin : g_chk
    $error("omsi_sync: W must be at least 1");
  end

  always_comb begin
    n.s1 = d;
    n.s2 = r.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= {RST_VAL, RST_VAL};
    end else begin
      r <= n;
    end
  end

  assign q = r.s2;
endmodule : omsi_sync
`default_nettype wire

// File: omsi_device.sv
// Device end: register decode, selection and interrupt pins
`default_nettype none
module omsi_device
  import omsi_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  omsi_bus_if.device bus,
  input wire logic dev_number,
  input wire logic chipselect_overlap_mode,
  input wire logic devbit_overlap_mode,
  input wire logic irq_set,
  input wire logic cc_set,
  input wire logic [7:0] status_in,
  input wire logic [7:0] error_in,
  input wire logic [omsi_pkg::TAG_W-1:0] tag_in,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic [omsi_pkg::TAG_W-1:0] cmd_tag,
  output logic cmd_ovl,
  output logic interrupt_disable_bit,
  output logic irq_pending
);
  import omsi_pkg::*;

  typedef struct packed {
    logic [15:0] dd_o;
    logic dd_oe_n;
    logic intrq_o;
    logic intrq_oe_n;
    logic second_interrupt_request_oe_n;
    logic dior_d;
    logic diow_d;
    logic rd_stat;
    logic [15:0] data;
    logic [7:0] feat;
    logic [7:0] seccnt;
    logic [7:0] secnum;
    logic [7:0] cyllo;
    logic [7:0] cylhi;
    logic [7:0] devhead;
    logic [7:0] devctl;
    logic pend;
    logic cc;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic [TAG_W-1:0] cmd_tag;
    logic cmd_ovl;
  } omsi_dev_s;

  omsi_dev_s r;
  omsi_dev_s n;

  logic s_cs0_n;
  logic s_cs1_n;
  logic [2:0] s_da;
  logic s_dior_n;
  logic s_diow_n;
  logic [15:0] s_dd;

  // Data goes through the same flops as the strobes to keep them aligned
  omsi_sync #(
    .W(23),
    .RST_VAL({2'h3, 3'h0, 2'h3, 16'hFFFF})
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({bus.host_cs0_n, bus.host_cs1_n, bus.host_da, bus.host_dior_n,
        bus.host_diow_n, bus.dd}),
    .q({s_cs0_n, s_cs1_n, s_da, s_dior_n, s_diow_n, s_dd})
  );

  function automatic logic [15:0] stat_word(input logic ovl,
      input logic cc, input logic [TAG_W-1:0] tag,
      input logic [7:0] st);
    if (ovl) begin
      return {cc, 3'h0, tag, st};
    end
    return {8'h00, st};
  endfunction : stat_word

  logic [1:0] hit;
  logic sel;
  logic ovl;
  logic rd_ok;
  logic wr_ok;
  logic rd_fall;
  logic rd_rise;
  logic wr_rise;
  logic clr_pend;
  logic act;
  logic busy_lock;

  always_comb begin
    n = r;
    n.cmd_valid = 1'b0;
    clr_pend = 1'b0;
    hit = omsi_decode(s_cs0_n, s_cs1_n, s_da, dev_number,
                      chipselect_overlap_mode);
    // Device bit only counts outside chip-select mode
    sel = chipselect_overlap_mode ? 1'b1 :
          (r.devhead[DEV_BIT] == dev_number);
    ovl = chipselect_overlap_mode || devbit_overlap_mode;
    // Command block writes locked in overlap modes while parameters are being saved
    busy_lock = ovl && status_in[BSY_BIT];
    rd_ok = (hit[1] || hit[0]) && sel;
    wr_ok = (hit[0] && sel) ||
            (hit[1] && !busy_lock &&
             (sel || (s_da == DA_DEVHEAD)));
    rd_fall = r.dior_d && !s_dior_n;
    rd_rise = !r.dior_d && s_dior_n;
    wr_rise = !r.diow_d && s_diow_n;
    n.dior_d = s_dior_n;
    n.diow_d = s_diow_n;

    if (rd_fall && rd_ok) begin
      n.dd_oe_n = 1'b0;
      n.rd_stat = hit[1] && (s_da == DA_STATCMD);
      if (hit[0]) begin
        n.dd_o = stat_word(ovl, r.cc, tag_in, status_in);
      end else begin
        // Upper byte of plain registers reads zero
        case (s_da)
          DA_DATA: n.dd_o = r.data;
          DA_ERR: n.dd_o = {8'h00, error_in};
          DA_SECCNT: n.dd_o = {8'h00, r.seccnt};
          DA_SECNUM: n.dd_o = {8'h00, r.secnum};
          DA_CYLLO: n.dd_o = {8'h00, r.cyllo};
          DA_CYLHI: n.dd_o = {8'h00, r.cylhi};
          DA_DEVHEAD: n.dd_o = {8'h00, r.devhead};
          DA_STATCMD: n.dd_o = stat_word(ovl, r.cc, tag_in, status_in);
          default: n.dd_o = 16'h0000;
        endcase
      end
    end
    if (rd_rise) begin
      n.dd_oe_n = 1'b1;
      n.rd_stat = 1'b0;
      clr_pend = r.rd_stat;
    end

    if (wr_rise && wr_ok) begin
      if (hit[0]) begin
        n.devctl = s_dd[7:0];
      end else begin
        case (s_da)
          DA_DATA: n.data = s_dd;
          DA_ERR: n.feat = s_dd[7:0];
          DA_SECCNT: n.seccnt = s_dd[7:0];
          DA_SECNUM: n.secnum = s_dd[7:0];
          DA_CYLLO: n.cyllo = s_dd[7:0];
          DA_CYLHI: n.cylhi = s_dd[7:0];
          DA_DEVHEAD: n.devhead = s_dd[7:0];
          DA_STATCMD: begin
            n.cmd_valid = 1'b1;
            n.cmd_code = s_dd[7:0];
            n.cmd_tag = ovl ? s_dd[TAG_LSB +: TAG_W] : '0;
            n.cmd_ovl = ovl && s_dd[OVL_BIT];
            clr_pend = 1'b1;
          end
          default: n.data = r.data;
        endcase
      end
    end

    // New events win over a clear in the same cycle
    n.pend = irq_set || (r.pend && !clr_pend);
    n.cc = cc_set || (r.cc && !(r.rd_stat && rd_rise));

    act = r.pend && !r.devctl[INTERRUPT_DISABLE_BIT_BIT];
    if (chipselect_overlap_mode) begin
      // Each device owns one line, so the host knows who asks
      n.intrq_oe_n = dev_number;
      n.intrq_o = act && !dev_number;
      n.second_interrupt_request_oe_n = !(dev_number && act);
    end else begin
      n.intrq_oe_n = !sel;
      n.intrq_o = act;
      n.second_interrupt_request_oe_n = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.dd_oe_n <= 1'b1;
      r.intrq_oe_n <= 1'b1;
      r.second_interrupt_request_oe_n <= 1'b1;
      r.dior_d <= 1'b1;
      r.diow_d <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign bus.dev_dd_o = r.dd_o;
  assign bus.dev_dd_oe_n = r.dd_oe_n;
  assign bus.dev_intrq_o = r.intrq_o;
  assign bus.dev_intrq_oe_n = r.intrq_oe_n;
  assign bus.dev_second_interrupt_request_oe_n = r.second_interrupt_request_oe_n;
  assign cmd_valid = r.cmd_valid;
  assign cmd_code = r.cmd_code;
  assign cmd_tag = r.cmd_tag;
  assign cmd_ovl = r.cmd_ovl;
  assign interrupt_disable_bit = r.devctl[INTERRUPT_DISABLE_BIT_BIT];
  assign irq_pending = r.pend;
endmodule : omsi_device
`default_nettype wire

// File: omsi_host.sv
// Host adapter end: AXI4-Lite register slave driving cable cycles
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
module omsi_host
  import omsi_pkg::*;
#(
  parameter int unsigned AXI_AW = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  omsi_bus_if.host bus,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import omsi_pkg::*;

  if (AXI_AW < 4 || STROBE_CYC < 8'd8) begin : g_chk
    $error("omsi_host: address too narrow or strobe too short");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD}
    omsi_host_e;

  typedef struct packed {
    omsi_host_e fsm;
    logic [7:0] cnt;
    logic cs0_n;
    logic cs1_n;
    logic [2:0] da;
    logic dior_n;
    logic diow_n;
    logic [15:0] dd_o;
    logic dd_oe_n;
    logic op_wr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic aw_held;
    logic [3:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata_axi;
  } omsi_host_s;

  omsi_host_s r;
  omsi_host_s n;
  logic [15:0] s_dd;
  logic s_intrq;
  logic s_second_interrupt_request_n;
  logic [31:0] status_w;

  omsi_sync #(
    .W(18),
    .RST_VAL({16'hFFFF, 2'h1})
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({bus.dd, bus.intrq, bus.second_interrupt_request_n}),
    .q({s_dd, s_intrq, s_second_interrupt_request_n})
  );

  always_comb begin
    n = r;
    status_w = {r.rdata, 13'h0000, !s_second_interrupt_request_n, s_intrq,
                (r.fsm != ST_IDLE)};
    if (s_axi_awvalid && r.awready) begin
      n.aw_held = 1'b1;
      n.aw_addr = s_axi_awaddr[3:0];
    end
    if (s_axi_wvalid && r.wready) begin
      n.w_held = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (r.aw_held && r.w_held && !r.bvalid) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (r.aw_addr)
        // A cycle ordered while one runs is dropped; poll busy first
        REG_OP: begin
          if (r.w_strb[0] && r.fsm == ST_IDLE) begin
            n.op_wr = r.w_data[OP_WR_BIT];
            n.da = r.w_data[OP_DA_LSB +: 3];
            n.cs0_n = !r.w_data[OP_CS0_BIT];
            n.cs1_n = !r.w_data[OP_CS1_BIT];
            n.dd_o = r.wdata;
            n.dd_oe_n = !r.w_data[OP_WR_BIT];
            n.cnt = SETUP_CYC - 8'd1;
            n.fsm = ST_SETUP;
          end
        end
        REG_WDATA: begin
          // Software zeroes the upper byte of plain registers
          if (r.w_strb[0]) n.wdata[7:0] = r.w_data[7:0];
          if (r.w_strb[1]) n.wdata[15:8] = r.w_data[15:8];
        end
        REG_STATUS: n.bresp = RESP_OKAY;
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    n.awready = !n.aw_held && !n.bvalid;
    n.wready = !n.w_held && !n.bvalid;

    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end
    if (s_axi_arvalid && r.arready) begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      case (s_axi_araddr[3:0])
        REG_OP: n.rdata_axi = {26'h0000000, !r.cs1_n, !r.cs0_n, r.da,
                               r.op_wr};
        REG_WDATA: n.rdata_axi = {16'h0000, r.wdata};
        REG_STATUS: n.rdata_axi = status_w;
        default: begin
          n.rdata_axi = 32'h00000000;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end

    case (r.fsm)
      ST_IDLE: n.cnt = r.cnt;
      ST_SETUP: begin
        if (r.cnt == 8'd0) begin
          n.dior_n = r.op_wr;
          n.diow_n = !r.op_wr;
          n.cnt = STROBE_CYC - 8'd1;
          n.fsm = ST_STROBE;
        end else begin
          n.cnt = r.cnt - 8'd1;
        end
      end
      ST_STROBE: begin
        if (r.cnt == 8'd0) begin
          n.dior_n = 1'b1;
          n.diow_n = 1'b1;
          // Upper byte of plain registers is kept but meaningless
          if (!r.op_wr) n.rdata = s_dd;
          n.cnt = RECOVER_CYC - 8'd1;
          n.fsm = ST_HOLD;
        end else begin
          n.cnt = r.cnt - 8'd1;
        end
      end
      ST_HOLD: begin
        if (r.cnt == 8'd0) begin
          n.dd_oe_n = 1'b1;
          n.cs0_n = 1'b1;
          n.cs1_n = 1'b1;
          n.fsm = ST_IDLE;
        end else begin
          n.cnt = r.cnt - 8'd1;
        end
      end
      default: n.fsm = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.fsm <= ST_IDLE;
      r.cs0_n <= 1'b1;
      r.cs1_n <= 1'b1;
      r.dior_n <= 1'b1;
      r.diow_n <= 1'b1;
      r.dd_oe_n <= 1'b1;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign bus.host_cs0_n = r.cs0_n;
  assign bus.host_cs1_n = r.cs1_n;
  assign bus.host_da = r.da;
  assign bus.host_dior_n = r.dior_n;
  assign bus.host_diow_n = r.diow_n;
  assign bus.host_dd_o = r.dd_o;
  assign bus.host_dd_oe_n = r.dd_oe_n;
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rdata = r.rdata_axi;
endmodule : omsi_host
`default_nettype wire

// File: omsi_properties.sv
// Concurrent checks on the cable between the host end and the device end
`default_nettype none
module omsi_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic chipselect_overlap_mode,
  input wire logic devbit_overlap_mode,
  input wire logic dev_number,
  input wire logic irq_pending,
  input wire logic interrupt_disable_bit,
  input wire logic host_cs0_n,
  input wire logic host_cs1_n,
  input wire logic [2:0] host_da,
  input wire logic host_dior_n,
  input wire logic host_diow_n,
  input wire logic host_dd_oe_n,
  input wire logic dev_dd_oe_n,
  input wire logic dev_intrq_o,
  input wire logic dev_intrq_oe_n,
  input wire logic dev_second_interrupt_request_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic cs0;
  logic cs1;
  logic act;
  assign cs0 = chipselect_overlap_mode && !dev_number;
  assign cs1 = chipselect_overlap_mode && dev_number;
  assign act = irq_pending && !interrupt_disable_bit;
  // Two samples absorb the one-cycle output latency
  AST_DEV0_IRQ: assert property ((cs0 && act) [*2] |->
    !dev_intrq_oe_n && dev_intrq_o) else $error("device 0 line idle");
  AST_DEV1_IRQ: assert property ((cs1 && act) [*2] |->
    !dev_second_interrupt_request_oe_n) else $error("device 1 second line idle");
  AST_SECOND_RELEASE: assert property ((cs1 && !act) [*2] |->
    dev_second_interrupt_request_oe_n) else $error("second line held without cause");
  AST_LINE_SPLIT: assert property ((cs0 [*2] |-> dev_second_interrupt_request_oe_n) and
    (cs1 [*2] |-> dev_intrq_oe_n || !dev_intrq_o))
    else $error("interrupt on wrong line");
  AST_DEVBIT_QUIET: assert property (
    (devbit_overlap_mode && !act) [*2] |-> dev_intrq_oe_n || !dev_intrq_o)
    else $error("primary line raised without cause");
  // Sync chain is two deep, five samples cover it
  AST_DEV0_CS_ONLY: assert property ((cs0 && !host_cs1_n) [*5] |->
    dev_dd_oe_n) else $error("device 0 answered other select");
  AST_DEV1_CS_ONLY: assert property ((cs1 && host_cs1_n) [*5] |->
    dev_dd_oe_n) else $error("device 1 answered other select");
  AST_CTL_OTHER: assert property (
    (cs0 && host_cs0_n && host_cs1_n && host_da != 3'h6) [*5] |->
    dev_dd_oe_n) else $error("control block drove unused address");
  AST_WRITE_DRIVES: assert property (!host_diow_n |->
    !host_dd_oe_n && host_dior_n) else $error("write strobe without data");
  AST_STROBE_HOLD: assert property ($fell(host_dior_n) |->
    $stable(host_da) && $stable(host_cs0_n) ##1 !host_dior_n [*7])
    else $error("read strobe unstable");
  cover property (cs0 && act && !dev_intrq_oe_n);
  cover property (!dev_second_interrupt_request_oe_n);
  cover property (devbit_overlap_mode && !dev_dd_oe_n);
endmodule : omsi_properties
`default_nettype wire

// File: omsi_bench.sv
// Self-checking bench: host end and device end joined across the cable
`default_nettype none
module omsi_bench import omsi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic dev_number = 1'b0, irq_set = 1'b0, cc_set = 1'b0;
  logic chipselect_overlap_mode = 1'b0, devbit_overlap_mode = 1'b0;
  logic [7:0] status_in = 8'h50, error_in = 8'h04, cmd_code;
  logic [3:0] tag_in = 4'h9, cmd_tag;
  logic cmd_valid, cmd_ovl, interrupt_disable_bit, irq_pending;
  int err_total = 0, cmp_count = 0, cmd_cnt = 0;
  omsi_bus_if bus ();
  // Second device absent: all of its drivers released
  assign bus.ext_dd_o = 16'h0000;
  assign bus.ext_dd_oe_n = 1'b1;
  assign bus.ext_intrq_o = 1'b0;
  assign bus.ext_intrq_oe_n = 1'b1;
  assign bus.ext_second_interrupt_request_oe_n = 1'b1;
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    if (cmd_valid === 1'b1) cmd_cnt <= cmd_cnt + 1;
  end
  omsi_host i_omsi_host (.aclk, .aresetn, .bus(bus),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  omsi_device i_omsi_device (.aclk, .aresetn, .bus(bus), .dev_number,
    .chipselect_overlap_mode, .devbit_overlap_mode, .irq_set, .cc_set,
    .status_in, .error_in, .tag_in, .cmd_valid, .cmd_code, .cmd_tag,
    .cmd_ovl, .interrupt_disable_bit, .irq_pending);
  omsi_properties i_omsi_properties (.aclk, .aresetn,
    .chipselect_overlap_mode, .devbit_overlap_mode, .dev_number,
    .irq_pending, .interrupt_disable_bit,
    .host_cs0_n(bus.host_cs0_n), .host_cs1_n(bus.host_cs1_n),
    .host_da(bus.host_da), .host_dior_n(bus.host_dior_n),
    .host_diow_n(bus.host_diow_n), .host_dd_oe_n(bus.host_dd_oe_n),
    .dev_dd_oe_n(bus.dev_dd_oe_n), .dev_intrq_o(bus.dev_intrq_o),
    .dev_intrq_oe_n(bus.dev_intrq_oe_n),
    .dev_second_interrupt_request_oe_n(bus.dev_second_interrupt_request_oe_n));

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] got,
      input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Every handshake and polling loop waits through here so a hang ends the run
  task automatic step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 400) begin
      err_total++;
      test_done();
    end
  endtask : step

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
      output logic [1:0] r);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      step(n);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
      output logic [1:0] r);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      step(n);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_rd

  // One cable cycle; c0/c1 high means that select is asserted
  task automatic cab(input logic w, input logic [2:0] da, input logic c0,
      input logic c1, input logic [15:0] wd, output logic [15:0] rd);
    logic [1:0] r;
    logic [31:0] v;
    int n;
    n = 0;
    axi_wr(REG_WDATA, {16'h0000, wd}, r);
    axi_wr(REG_OP, {26'h0, c1, c0, da, w}, r);
    v = 32'h1;
    while (v[0]) begin
      step(n);
      axi_rd(REG_STATUS, v, r);
    end
    rd = v[31:16];
  endtask : cab

  task automatic set_mode(input logic dn, input logic cm, input logic bm);
    @(posedge aclk);
    dev_number <= dn;
    chipselect_overlap_mode <= cm;
    devbit_overlap_mode <= bm;
    repeat (2) @(posedge aclk);
  endtask : set_mode

  task automatic pulse();
    @(posedge aclk);
    irq_set <= 1'b1;
    cc_set <= 1'b1;
    @(posedge aclk);
    irq_set <= 1'b0;
    cc_set <= 1'b0;
  endtask : pulse

  // Leaves room for the pending flop and the pin flop
  task automatic lines(input logic p, input logic s);
    repeat (4) @(posedge aclk);
    chk("primary line", 32'(bus.intrq), 32'(p));
    chk("second line", 32'(bus.second_interrupt_request_n), 32'(s));
  endtask : lines

  task automatic t_axi();
    logic [31:0] v;
    logic [1:0] r;
    axi_rd(4'hC, v, r);
    chk("unmapped read resp", 32'(r), 32'(RESP_SLVERR));
    chk("unmapped read data", v, 32'h0);
    axi_wr(4'hC, 32'h0, r);
    chk("unmapped write resp", 32'(r), 32'(RESP_SLVERR));
    axi_wr(REG_WDATA, 32'h0000A55A, r);
    chk("wdata write resp", 32'(r), 32'(RESP_OKAY));
    axi_rd(REG_WDATA, v, r);
    chk("wdata readback", v, 32'h0000A55A);
    chk("wdata read resp", 32'(r), 32'(RESP_OKAY));
  endtask : t_axi

  task automatic t_cs_irq();
    logic [31:0] v;
    logic [1:0] r;
    logic [15:0] rd;
    for (int d = 0; d < 2; d++) begin
      set_mode(d[0], 1'b1, 1'b0);
      pulse();
      lines(d == 0, d == 0);
      axi_rd(REG_STATUS, v, r);
      chk("host line view", 32'(v[2:1]), d == 0 ? 32'h1 : 32'h2);
      cab(1'b1, DA_ALTCTL, 1'b0, d[0], 16'h0002, rd);
      lines(1'b0, 1'b1);
      chk("disable bit", 32'(interrupt_disable_bit), 32'h1);
      cab(1'b1, DA_ALTCTL, 1'b0, d[0], 16'h0000, rd);
      lines(d == 0, d == 0);
      cab(1'b0, DA_STATCMD, 1'b1, d[0], 16'h0000, rd);
      chk("status", 32'(rd), 32'({4'h8, tag_in, status_in}));
      lines(1'b0, 1'b1);
      chk("pending cleared", 32'(irq_pending), 32'h0);
      cab(1'b0, DA_STATCMD, 1'b1, d[0], 16'h0000, rd);
      chk("status again", 32'(rd), 32'({4'h0, tag_in, status_in}));
    end
  endtask : t_cs_irq

  task automatic t_cs_sel();
    logic [15:0] rd;
    logic [15:0] own;
    for (int d = 0; d < 2; d++) begin
      own = d[0] ? 16'h0022 : 16'h0011;
      set_mode(d[0], 1'b1, 1'b0);
      cab(1'b1, DA_DEVHEAD, 1'b1, d[0], d[0] ? 16'h0 : 16'h10, rd);
      cab(1'b1, DA_SECCNT, 1'b1, d[0], own, rd);
      cab(1'b1, DA_SECCNT, 1'b1, !d[0], 16'h00EE, rd);
      cab(1'b0, DA_SECCNT, 1'b1, d[0], 16'h0, rd);
      chk("own sector count", 32'(rd), 32'(own));
      cab(1'b0, DA_SECCNT, 1'b1, !d[0], 16'h0, rd);
      chk("other select", 32'(rd), 32'hFFFF);
      cab(1'b0, DA_ALTCTL, 1'b0, d[0], 16'h0, rd);
      chk("alt status", 32'(rd), 32'({4'h0, tag_in, status_in}));
      cab(1'b0, 3'h5, 1'b0, d[0], 16'h0, rd);
      chk("unused control", 32'(rd), 32'hFFFF);
    end
  endtask : t_cs_sel

  task automatic t_devbit();
    logic [15:0] rd;
    set_mode(1'b0, 1'b0, 1'b1);
    cab(1'b1, DA_DEVHEAD, 1'b1, 1'b0, 16'h0000, rd);
    cab(1'b1, DA_SECCNT, 1'b1, 1'b0, 16'h0033, rd);
    cab(1'b1, DA_DEVHEAD, 1'b1, 1'b0, 16'h0010, rd);
    cab(1'b1, DA_SECCNT, 1'b1, 1'b0, 16'h0044, rd);
    cab(1'b0, DA_STATCMD, 1'b1, 1'b0, 16'h0, rd);
    chk("unselected read", 32'(rd), 32'hFFFF);
    pulse();
    lines(1'b0, 1'b1);
    cab(1'b1, DA_DEVHEAD, 1'b1, 1'b0, 16'h0000, rd);
    lines(1'b1, 1'b1);
    // Busy locks the command block
    status_in <= 8'hD0;
    cab(1'b1, DA_SECCNT, 1'b1, 1'b0, 16'h0055, rd);
    status_in <= 8'h50;
    cab(1'b0, DA_SECCNT, 1'b1, 1'b0, 16'h0, rd);
    chk("kept sector count", 32'(rd), 32'h0033);
    set_mode(1'b0, 1'b0, 1'b0);
    cab(1'b0, DA_STATCMD, 1'b1, 1'b0, 16'h0, rd);
    chk("legacy status", 32'(rd), 32'({8'h00, status_in}));
  endtask : t_devbit

  task automatic t_cmd();
    logic [15:0] rd;
    int c0;
    set_mode(1'b1, 1'b1, 1'b0);
    pulse();
    lines(1'b0, 1'b0);
    c0 = cmd_cnt;
    cab(1'b1, DA_STATCMD, 1'b1, 1'b1, 16'h8AEC, rd);
    chk("command count", 32'(cmd_cnt - c0), 32'h1);
    chk("command code", 32'(cmd_code), 32'hEC);
    chk("command tag", 32'(cmd_tag), 32'hA);
    chk("overlap flag", 32'(cmd_ovl), 32'h1);
    lines(1'b0, 1'b1);
  endtask : t_cmd

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_axi();
    t_cs_irq();
    t_cs_sel();
    t_devbit();
    t_cmd();
    test_done();
  end
endmodule : omsi_bench
`default_nettype wire
